/* File: rtl/tws_map.vh */
// Constants shared by the two-wire memory slave design files.
`ifndef TWS_MAP_VH
`define TWS_MAP_VH

// Widths and depths.
`define TWS_AW          11
`define TWS_DW          8
`define TWS_FW          19
`define TWS_FDEPTH      16
`define TWS_FAW         4
`define TWS_MEM_WORDS   2048

// Reset and limit values.
`define TWS_ADDR_RST    11'h000
`define TWS_ADDR_LAST   11'h7FF
`define TWS_BYTE_RST    8'h00
`define TWS_BIT_RST     3'h0
`define TWS_BIT_LAST    3'h7
`define TWS_BIT_ONE     3'h1
`define TWS_PAGE_RST    3'h0

// Slave address byte and address latch fields.
`define TWS_SA_TYPE     7:4
`define TWS_SA_PAGE     3:1
`define TWS_SA_RW       0
`define TWS_ADDR_LOW    7:0
`define TWS_ADDR_PAGE   10:8

// Protocol states.
`define TWS_ST_IDLE     4'h0
`define TWS_ST_SLV      4'h1
`define TWS_ST_SLV_ACK  4'h2
`define TWS_ST_WORD     4'h3
`define TWS_ST_WORD_ACK 4'h4
`define TWS_ST_WDAT     4'h5
`define TWS_ST_WDAT_ACK 4'h6
`define TWS_ST_RDAT     4'h7
`define TWS_ST_RDAT_ACK 4'h8

`endif

/* File: rtl/tws_fifo.v */
// Parameterised synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps

module tws_fifo #(
  parameter W     = 19,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire         sys_clk,
  input  wire         rst_b,
  // Filling side
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  // Draining side
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] store [0:DEPTH-1];
  reg [AW:0]  wr_ptr;
  reg [AW:0]  rd_ptr;

  wire        push;
  wire        pop;

  // Full when the pointers differ only in the wrap bit.
  assign in_ready  = ~((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data  = store[rd_ptr[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge sys_clk) begin
    if (push) begin
      store[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule

/* File: rtl/tws_mem.v */
// Byte-wide storage array with one write port and one registered read port.
`timescale 1ns/10ps
`include "tws_map.vh"

module tws_mem (
  // Clock
  input  wire                sys_clk,
  // Write port
  input  wire                wr_en,
  input  wire [`TWS_AW-1:0]  wr_addr,
  input  wire [`TWS_DW-1:0]  wr_data,
  // Read port
  input  wire                rd_en,
  input  wire [`TWS_AW-1:0]  rd_addr,
  output reg  [`TWS_DW-1:0]  rd_data
);

  reg [`TWS_DW-1:0] cells [0:`TWS_MEM_WORDS-1];

  always @(posedge sys_clk) begin
    if (wr_en) begin
      cells[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= cells[rd_addr];
    end
  end

endmodule

/* File: rtl/tws_slave.v */
// Two-wire bus slave front end of a 2,048-byte serial memory.
// Function
// - Ninth clock after eight bits is the acknowledge slot; receiver pulls low.
// - Missing acknowledge aborts the operation; device becomes addressable again.
// - Slave address: type in bits 7-4, page in 3-1, read/write in bit 0.
// - Write: word address byte joins page select into latched 11-bit address.
// - Read: new page select latched, low eight latch bits kept.
// - Address latch increments after each read or acknowledged write data byte, wrapping 7FFh to 000h.
// - Unlimited consecutive data bytes per transaction, address keeps advancing.
// - Data shifts MSB first; read acknowledge decides on the next byte.
// - Write: each received data byte is acknowledged unless write protect is high or the write queue is full.
// - No busy period; new transactions are accepted right after a write.
// - Array write at eighth bit; earlier start or stop leaves memory unchanged.
// - Write protect high: data bytes not acknowledged, address not incremented.
// - Read data starts after the acknowledge, from page and low latch bits.
// - Each master acknowledge fetches and sends the next sequential byte.
// - Repeated start after word address keeps the address for the read.
// - Start is data falling with clock high; stop is data rising.
// - A start anywhere aborts and waits for a new slave address.
// - A stop aborts any pending operation and returns to idle.
// - Drive data after clock falls; sample data on clock rise.
`timescale 1ns/10ps
`include "tws_map.vh"

module tws_slave #(
  // Device-type code that the slave address must carry; the value is arbitrary.
  parameter [3:0] DEV_TYPE = 4'h5
) (
  // Clock and reset
  input  wire                sys_clk,
  input  wire                rst_b,
  // Two-wire bus, open drain data
  input  wire                scl_in,
  input  wire                sda_in,
  output reg                 sda_out,
  output reg                 sda_oe,
  // Control
  input  wire                wr_protect,
  // Status
  output reg  [`TWS_AW-1:0]  cur_addr,
  output reg                 busy
);

  // Address increment with explicit wrap at the top of the array.
  function [`TWS_AW-1:0] addr_next;
    input [`TWS_AW-1:0] a;
    begin
      if (a == `TWS_ADDR_LAST) begin
        addr_next = `TWS_ADDR_RST;
      end else begin
        addr_next = a + {{(`TWS_AW-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  // Synchronisers; the first stage feeds only the second.
  reg                 scl_m;
  reg                 scl_s;
  reg                 scl_d;
  reg                 sda_m;
  reg                 sda_s;
  reg                 sda_d;

  // Protocol state.
  reg  [3:0]          state;
  reg  [2:0]          bit_cnt;
  reg  [`TWS_DW-1:0]  rx_byte;
  reg  [`TWS_DW-1:0]  tx_byte;
  reg  [`TWS_DW-1:0]  rd_buf;
  reg  [2:0]          page;
  reg                 rd_mode;
  reg                 ack_go;
  reg                 ack_phase;

  // Memory fetch and write queue handshakes.
  reg                 fetch_req;
  reg  [`TWS_AW-1:0]  fetch_addr;
  reg                 fetch_load;
  reg                 push_valid;
  reg  [`TWS_FW-1:0]  push_data;

  wire                scl_rise;
  wire                scl_fall;
  wire                bus_start;
  wire                bus_stop;
  wire [`TWS_DW-1:0]  rx_next;
  wire                last_bit;
  wire                fifo_in_ready;
  wire                fifo_out_valid;
  wire                fifo_out_ready;
  wire [`TWS_FW-1:0]  fifo_out_data;
  wire                mem_we;
  wire [`TWS_DW-1:0]  mem_rdata;

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  // Data may only move with the clock high at a start or a stop.
  assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
  assign rx_next   = {rx_byte[`TWS_DW-2:0], sda_s};
  assign last_bit  = (bit_cnt == `TWS_BIT_LAST);

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      state      <= `TWS_ST_IDLE;
      bit_cnt    <= `TWS_BIT_RST;
      rx_byte    <= `TWS_BYTE_RST;
      tx_byte    <= `TWS_BYTE_RST;
      page       <= `TWS_PAGE_RST;
      rd_mode    <= 1'b0;
      ack_go     <= 1'b0;
      ack_phase  <= 1'b0;
      cur_addr   <= `TWS_ADDR_RST;
      sda_out    <= 1'b0;
      sda_oe     <= 1'b0;
      fetch_req  <= 1'b0;
      fetch_addr <= `TWS_ADDR_RST;
      push_valid <= 1'b0;
      push_data  <= {`TWS_FW{1'b0}};
      busy       <= 1'b0;
    end else begin
      fetch_req  <= 1'b0;
      push_valid <= 1'b0;
      busy       <= (state != `TWS_ST_IDLE);
      if (bus_start) begin
        // A half-received byte is dropped, so nothing reaches the array.
        state     <= `TWS_ST_SLV;
        bit_cnt   <= `TWS_BIT_RST;
        ack_phase <= 1'b0;
        sda_oe    <= 1'b0;
      end else if (bus_stop) begin
        state     <= `TWS_ST_IDLE;
        bit_cnt   <= `TWS_BIT_RST;
        ack_phase <= 1'b0;
        sda_oe    <= 1'b0;
      end else begin
        case (state)
          `TWS_ST_SLV, `TWS_ST_WORD, `TWS_ST_WDAT: begin
            if (scl_rise) begin
              rx_byte <= rx_next;
              bit_cnt <= bit_cnt + `TWS_BIT_ONE;
              if (last_bit) begin
                ack_phase <= 1'b0;
                bit_cnt   <= `TWS_BIT_RST;
                if (state == `TWS_ST_SLV) begin
                  state <= `TWS_ST_SLV_ACK;
                  if (rx_next[`TWS_SA_TYPE] == DEV_TYPE) begin
                    ack_go  <= 1'b1;
                    page    <= rx_next[`TWS_SA_PAGE];
                    rd_mode <= rx_next[`TWS_SA_RW];
                    if (rx_next[`TWS_SA_RW]) begin
                      cur_addr   <= {rx_next[`TWS_SA_PAGE], cur_addr[`TWS_ADDR_LOW]};
                      fetch_addr <= {rx_next[`TWS_SA_PAGE], cur_addr[`TWS_ADDR_LOW]};
                      fetch_req  <= 1'b1;
                    end
                  end else begin
                    ack_go <= 1'b0;
                  end
                end else if (state == `TWS_ST_WORD) begin
                  state    <= `TWS_ST_WORD_ACK;
                  ack_go   <= 1'b1;
                  cur_addr <= {page, rx_next};
                end else begin
                  state <= `TWS_ST_WDAT_ACK;
                  // A full queue is refused the same way as a protected write.
                  if (wr_protect || !fifo_in_ready) begin
                    ack_go <= 1'b0;
                  end else begin
                    ack_go     <= 1'b1;
                    push_valid <= 1'b1;
                    push_data  <= {cur_addr, rx_next};
                    cur_addr   <= addr_next(cur_addr);
                  end
                end
              end
            end
          end
          `TWS_ST_SLV_ACK, `TWS_ST_WORD_ACK, `TWS_ST_WDAT_ACK: begin
            if (scl_fall) begin
              if (!ack_phase) begin
                ack_phase <= 1'b1;
                sda_oe    <= ack_go;
              end else begin
                ack_phase <= 1'b0;
                sda_oe    <= 1'b0;
                bit_cnt   <= `TWS_BIT_RST;
                if (!ack_go) begin
                  state <= `TWS_ST_IDLE;
                end else if (state == `TWS_ST_SLV_ACK) begin
                  if (rd_mode) begin
                    state   <= `TWS_ST_RDAT;
                    sda_oe  <= ~rd_buf[`TWS_DW-1];
                    tx_byte <= {rd_buf[`TWS_DW-2:0], 1'b0};
                  end else begin
                    state <= `TWS_ST_WORD;
                  end
                end else begin
                  state <= `TWS_ST_WDAT;
                end
              end
            end
          end
          `TWS_ST_RDAT: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + `TWS_BIT_ONE;
              if (last_bit) begin
                state     <= `TWS_ST_RDAT_ACK;
                bit_cnt   <= `TWS_BIT_RST;
                ack_phase <= 1'b0;
                ack_go    <= 1'b0;
                cur_addr  <= addr_next(cur_addr);
              end
            end else if (scl_fall) begin
              sda_oe  <= ~tx_byte[`TWS_DW-1];
              tx_byte <= {tx_byte[`TWS_DW-2:0], 1'b0};
            end
          end
          `TWS_ST_RDAT_ACK: begin
            if (scl_fall && !ack_phase) begin
              sda_oe    <= 1'b0;
              ack_phase <= 1'b1;
            end else if (scl_rise && ack_phase && !ack_go) begin
              if (!sda_s) begin
                ack_go     <= 1'b1;
                fetch_req  <= 1'b1;
                fetch_addr <= cur_addr;
              end else begin
                // Without an acknowledge the line stays free for the stop.
                state     <= `TWS_ST_IDLE;
                ack_phase <= 1'b0;
              end
            end else if (scl_fall && ack_go) begin
              state     <= `TWS_ST_RDAT;
              ack_phase <= 1'b0;
              sda_oe    <= ~rd_buf[`TWS_DW-1];
              tx_byte   <= {rd_buf[`TWS_DW-2:0], 1'b0};
            end
          end
          default: begin
            state  <= `TWS_ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // The fetched byte is held until the next clock fall starts sending it.
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      fetch_load <= 1'b0;
      rd_buf     <= `TWS_BYTE_RST;
    end else begin
      fetch_load <= fetch_req;
      if (fetch_load) begin
        rd_buf <= mem_rdata;
      end
    end
  end

  // Reads take the array ahead of queued writes and stall the drain for one cycle.
  // A queued write drains long before the next bus bit, so a read right after
  // a write still sees fresh data at any legal bus rate.
  assign fifo_out_ready = ~fetch_req;
  assign mem_we         = fifo_out_valid & fifo_out_ready;

  tws_fifo #(
    .W     (`TWS_FW),
    .DEPTH (`TWS_FDEPTH),
    .AW    (`TWS_FAW)
  ) u_wr_fifo (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .in_valid  (push_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  tws_mem u_mem (
    .sys_clk (sys_clk),
    .wr_en   (mem_we),
    .wr_addr (fifo_out_data[`TWS_FW-1:`TWS_DW]),
    .wr_data (fifo_out_data[`TWS_DW-1:0]),
    .rd_en   (fetch_req),
    .rd_addr (fetch_addr),
    .rd_data (mem_rdata)
  );

endmodule

/* File: testbench/tws_bus_master.sv */
// Bus master model that drives the far side of the memory slave.
`timescale 1ns/10ps

module tws_bus_master #(
  parameter int HALF = 12
) (
  // Clock
  input  wire  sys_clk,
  // Bus
  input  wire  sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b0;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Data moves two cycles after the clock falls, so the slave never sees a false start or stop.
  task automatic bit_io(input logic b, output logic s);
    sda_low <= ~b;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF / 2);
    s = sda;
    tick(HALF / 2);
    scl <= 1'b0;
    tick(2);
  endtask

  task automatic start_c();
    sda_low <= 1'b0;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_low <= 1'b1;
    tick(HALF);
    scl <= 1'b0;
    tick(HALF);
  endtask

  // The clock is parked low after a stop, so idle noise on the data line cannot look like a start.
  task automatic stop_c();
    sda_low <= 1'b1;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_low <= 1'b0;
    tick(HALF);
    scl <= 1'b0;
    tick(HALF);
  endtask

  task automatic put_byte(input logic [7:0] d, input int n, output logic ack);
    logic s;
    ack = 1'b0;
    for (int i = 7; i > 7 - n; i--) bit_io(d[i], s);
    if (n == 8) begin
      bit_io(1'b1, s);
      ack = ~s;
    end
  endtask

  task automatic get_byte(output logic [7:0] d, input logic more);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~more, s);
  endtask
endmodule

/* File: testbench/tws_slave_properties.sv */
// Concurrent checks on the ports of the two-wire memory slave.
`timescale 1ns/10ps
`include "tws_map.vh"

module tws_slave_properties (
  // Clock and reset
  input wire               sys_clk,
  input wire               rst_b,
  // Bus
  input wire               scl_in,
  input wire               sda_in,
  input wire               sda_out,
  input wire               sda_oe,
  // Control and status
  input wire               wr_protect,
  input wire [`TWS_AW-1:0] cur_addr,
  input wire               busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_start;
    scl_in && $past(scl_in) && $fell(sda_in);
  endsequence
  sequence s_stop;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence

  property p_open_drain;
    sda_oe |-> !sda_out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("Data line driven high");
  property p_ack_hold;
    $rose(sda_oe) |-> sda_oe [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("Low drive too short");
  property p_change_low;
    $changed(sda_oe) |-> !scl_in;
  endproperty
  a_change_low: assert property (p_change_low) else $error("Drive changed with clock high");
  property p_after_fall;
    $rose(sda_oe) |-> !$past(scl_in, 2);
  endproperty
  a_after_fall: assert property (p_after_fall) else $error("Drive began too early");
  property p_addr_on_rise;
    $changed(cur_addr) |-> scl_in;
  endproperty
  a_addr_on_rise: assert property (p_addr_on_rise) else $error("Address moved with clock low");
  property p_start_busy;
    s_start |-> ##[1:6] busy;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("Start not taken");
  property p_stop_idle;
    s_stop |-> ##[1:8] !busy;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("Stop did not idle");
  property p_drive_busy;
    sda_oe |-> busy;
  endproperty
  a_drive_busy: assert property (p_drive_busy) else $error("Drive while idle");
  property p_reset;
    disable iff (1'b0) !rst_b |=> cur_addr == `TWS_ADDR_RST && !busy && !sda_oe;
  endproperty
  a_reset: assert property (p_reset) else $error("Reset values wrong");
endmodule

bind tws_slave tws_slave_properties u_props (
  .sys_clk    (sys_clk),
  .rst_b      (rst_b),
  .scl_in     (scl_in),
  .sda_in     (sda_in),
  .sda_out    (sda_out),
  .sda_oe     (sda_oe),
  .wr_protect (wr_protect),
  .cur_addr   (cur_addr),
  .busy       (busy)
);

/* File: testbench/two_wire_memory_slave_tb.sv */
// Self-checking testbench for the two-wire memory slave.
`timescale 1ns/10ps
`include "tws_map.vh"

module two_wire_memory_slave_tb;
  localparam int   LIMIT = 40000;
  localparam [3:0] TYPE = 4'h5;
  logic               sys_clk = 1'b0;
  logic               rst_b = 1'b0;
  logic               wr_protect = 1'b0;
  wire                scl;
  wire                m_low;
  wire                sda_out;
  wire                sda_oe;
  wire                sda;
  wire  [`TWS_AW-1:0] cur_addr;
  wire                busy;
  int                 bad_count = 0;
  int                 checked = 0;
  int                 cycles = 0;
  logic               ack;
  logic [7:0]         rd;

  // Pull-up wire: either party pulling low wins.
  assign sda = (sda_oe ? sda_out : 1'b1) & ~m_low;

  always #2.5 sys_clk = ~sys_clk;

  tws_slave #(.DEV_TYPE(TYPE)) dut (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .scl_in     (scl),
    .sda_in     (sda),
    .sda_out    (sda_out),
    .sda_oe     (sda_oe),
    .wr_protect (wr_protect),
    .cur_addr   (cur_addr),
    .busy       (busy)
  );

  tws_bus_master u_m (
    .sys_clk (sys_clk),
    .sda     (sda),
    .scl     (scl),
    .sda_low (m_low)
  );

  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic put(input logic [7:0] d, input logic exp_ack);
    u_m.put_byte(d, 8, ack);
    chk("ack", {10'h000, ack}, {10'h000, exp_ack});
  endtask

  task automatic get(input logic [7:0] exp, input logic more);
    u_m.get_byte(rd, more);
    chk("read data", {3'h0, rd}, {3'h0, exp});
  endtask

  task automatic sa(input logic [2:0] page, input logic rw);
    u_m.start_c();
    put({TYPE, page, rw}, 1'b1);
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    chk("reset addr", cur_addr, 11'h000);
    chk("reset busy", {10'h000, busy}, 11'h000);
    sa(3'h7, 1'b0);
    put(8'hFF, 1'b1);
    put(8'hB1, 1'b1);
    put(8'hB2, 1'b1);
    u_m.stop_c();
    chk("wrap addr", cur_addr, 11'h001);
    sa(3'h7, 1'b0);
    put(8'hFF, 1'b1);
    sa(3'h7, 1'b1);
    get(8'hB1, 1'b1);
    get(8'hB2, 1'b0);
    u_m.stop_c();
    chk("read addr", cur_addr, 11'h001);
    sa(3'h6, 1'b0);
    put(8'h03, 1'b1);
    put(8'h5A, 1'b1);
    sa(3'h1, 1'b0);
    put(8'h02, 1'b1);
    put(8'hC3, 1'b1);
    u_m.stop_c();
    sa(3'h6, 1'b1);
    get(8'h5A, 1'b0);
    u_m.stop_c();
    chk("page addr", cur_addr, 11'h604);
    u_m.start_c();
    put({TYPE ^ 4'h3, 3'h0, 1'b1}, 1'b0);
    u_m.stop_c();
    chk("kept addr", cur_addr, 11'h604);
    sa(3'h0, 1'b0);
    put(8'h10, 1'b1);
    put(8'h11, 1'b1);
    wr_protect <= 1'b1;
    sa(3'h0, 1'b0);
    put(8'h10, 1'b1);
    put(8'h77, 1'b0);
    u_m.stop_c();
    chk("protect addr", cur_addr, 11'h010);
    wr_protect <= 1'b0;
    sa(3'h0, 1'b0);
    put(8'h10, 1'b1);
    u_m.put_byte(8'hEE, 4, ack);
    sa(3'h0, 1'b1);
    get(8'h11, 1'b0);
    u_m.stop_c();
    chk("final addr", cur_addr, 11'h011);
    tally_and_finish();
  end
endmodule
